//--- hw/csr_params.svh
// constants for the cpu special register core
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH
`define CSR_ADDR_INDIRECT 6'h00
`define CSR_ADDR_RTC 6'h01
`define CSR_ADDR_PCL 6'h02
`define CSR_ADDR_STATUS 6'h03
`define CSR_ADDR_RAMSEL 6'h04
`define CSR_ADDR_PORT5 6'h05
`define CSR_ADDR_PORT6 6'h06
`define CSR_ST_CARRY 0
`define CSR_ST_NIBBLE 1
`define CSR_ST_ZERO 2
`define CSR_ST_PDOWN 3
`define CSR_ST_TOUT 4
`define CSR_ST_PAGE_LSB 5
`define CSR_P5_CPAGE 0
`define CSR_P5_RAMMSB 1
`define CSR_P5_DATA_LSB 4
`define CSR_P5_RSVD_MASK 8'hF3
`define CSR_RST_STATUS 8'h18
`define CSR_RST_BYTE 8'h00
`define CSR_RST_PC 13'h0000
`endif

//--- hw/csr_pkg.sv
// types for the cpu special register core
package csr_pkg;
   typedef enum logic [2:0] {
      CSR_RUN = 3'b001,
      CSR_SLEEP = 3'b010,
      CSR_IDLE = 3'b100
   } csr_mode_t;
endpackage : csr_pkg

//--- hw/csr_core.sv
// special function registers of the cpu core
`timescale 1ns/10ps
`include "csr_params.svh"
module csr_core
   import csr_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic reset_n_pin,
   // register access from the core
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [7:0] indirect_addr,
   output logic indirect_wr,
   output logic indirect_rd,
   output logic [7:0] indirect_wdata,
   input wire logic [7:0] indirect_rdata,
   // program flow
   input wire logic jump_instr,
   input wire logic call_instr,
   input wire logic return_instr,
   input wire logic pc_step,
   input wire logic pc_add,
   input wire logic [9:0] branch_target,
   output logic [12:0] pc,
   // flags from the alu
   input wire logic flags_we,
   input wire logic carry_in,
   input wire logic nibble_carry_in,
   input wire logic zero_in,
   // power events
   input wire logic sleep_instr,
   input wire logic idle_select,
   input wire logic watchdog_clear_instr,
   input wire logic watchdog_timeout,
   // pins
   input wire logic rtc_pin,
   input wire logic rtc_from_pin,
   input wire logic infrared_output_pin,
   input wire logic [7:0] port6_pins,
   input wire logic [7:0] port6_gpio,
   input wire logic [7:0] port8_pins,
   input wire logic [7:0] port8_gpio,
   input wire logic ext_irq_a_pin,
   input wire logic ext_irq_b_pin,
   input wire logic ext_irq_a_rising,
   // outputs to the rest of the chip
   output logic control_page_select,
   output logic data_ram_msb,
   output logic [1:0] bank_sel,
   output logic [3:0] port5_data,
   output logic [7:0] port6_data,
   output logic ext_irq_a,
   output logic ext_irq_b,
   output logic wake,
   output logic sleeping
);
   localparam int SPW = $clog2(STACK_DEPTH);

   // ************************************
   // state
   // ************************************
   typedef struct packed {
      logic [7:0] rtc;
      logic [12:0] pc;
      logic [7:0] status;
      logic [7:0] ram_sel;
      logic [7:0] port5;
      logic [7:0] port6;
      logic [SPW-1:0] sp;
      logic rtc_q;
      logic irq_a_q;
      logic irq_b_q;
      logic irq_a;
      logic irq_b;
      logic [17:0] pins_q;
      logic wake;
      logic [7:0] rdata;
      logic [7:0] iaddr;
      logic iwr;
      logic ird;
      logic [7:0] iwdata;
      logic asleep;
      csr_mode_t mode;
   } csr_state_t;

   csr_state_t s;
   csr_state_t next_s;
   logic [12:0] stack [STACK_DEPTH];
   logic reset_any;
   logic [17:0] pins_now;
   logic [17:0] pins_en;
   logic [7:0] pcl_sum;
   logic [7:0] rd_mux;

   assign reset_any = rst | ~reset_n_pin;
   assign pins_now = {rtc_pin, infrared_output_pin, port6_pins, port8_pins};
   assign pins_en = {2'b11, port6_gpio, port8_gpio};
   assign pcl_sum = s.pc[7:0] + reg_wdata;

   // ************************************
   // read path
   // ************************************
   always_comb begin
      case (reg_addr)
         `CSR_ADDR_INDIRECT: rd_mux = indirect_rdata;
         `CSR_ADDR_RTC: rd_mux = s.rtc;
         `CSR_ADDR_PCL: rd_mux = s.pc[7:0];
         `CSR_ADDR_STATUS: rd_mux = s.status;
         `CSR_ADDR_RAMSEL: rd_mux = s.ram_sel;
         `CSR_ADDR_PORT5: rd_mux = s.port5 & `CSR_P5_RSVD_MASK;
         `CSR_ADDR_PORT6: rd_mux = s.port6;
         default: rd_mux = `CSR_RST_BYTE;
      endcase
   end

   // ************************************
   // next state
   // ************************************
   always_comb begin
      next_s = s;
      next_s.rdata = reg_rd ? rd_mux : s.rdata;
      next_s.rtc_q = rtc_pin;
      next_s.irq_a_q = ext_irq_a_pin;
      next_s.irq_b_q = ext_irq_b_pin;
      next_s.pins_q = pins_now;
      // indirect strobes leave a cycle late so the ram sees a settled address
      next_s.iaddr = s.ram_sel;
      next_s.iwr = reg_wr && (reg_addr == `CSR_ADDR_INDIRECT);
      next_s.ird = reg_rd && (reg_addr == `CSR_ADDR_INDIRECT);
      next_s.iwdata = reg_wdata;
      next_s.irq_a = ext_irq_a_rising ? (ext_irq_a_pin & ~s.irq_a_q)
                                      : (~ext_irq_a_pin & s.irq_a_q);
      next_s.irq_b = ~ext_irq_b_pin & s.irq_b_q;
      // level changes only count in low power; registered as a pulse
      next_s.wake = (s.mode != CSR_RUN) && (|((pins_now ^ s.pins_q) & pins_en));
      if (rtc_from_pin ? (rtc_pin & ~s.rtc_q) : 1'b1) begin
         next_s.rtc = s.rtc + 8'h01;
      end
      // program counter
      if (pc_step) begin
         next_s.pc = s.pc + 13'h0001;
      end
      if (jump_instr) begin
         next_s.pc = {s.status[7:5], branch_target};
      end else if (call_instr) begin
         next_s.pc = {s.status[7:5], branch_target};
         next_s.sp = s.sp + 1'b1;
      end else if (return_instr) begin
         next_s.pc = stack[s.sp - 1'b1];
         next_s.sp = s.sp - 1'b1;
      end else if (reg_wr && reg_addr == `CSR_ADDR_PCL) begin
         if (pc_add) begin
            next_s.pc = {s.pc[12:8], pcl_sum};
         end else begin
            next_s.pc = {s.pc[12:8], reg_wdata};
         end
      end
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            `CSR_ADDR_RTC: next_s.rtc = reg_wdata;
            `CSR_ADDR_STATUS: begin
               // timeout and power-down are not writable by software
               next_s.status = {reg_wdata[7:5], s.status[4:3], reg_wdata[2:0]};
            end
            `CSR_ADDR_RAMSEL: next_s.ram_sel = reg_wdata;
            `CSR_ADDR_PORT5: next_s.port5 = reg_wdata & `CSR_P5_RSVD_MASK;
            `CSR_ADDR_PORT6: next_s.port6 = reg_wdata;
            default: ;
         endcase
      end
      if (flags_we) begin
         next_s.status[`CSR_ST_CARRY] = carry_in;
         next_s.status[`CSR_ST_NIBBLE] = nibble_carry_in;
         next_s.status[`CSR_ST_ZERO] = zero_in;
      end
      // power flags and mode
      case (s.mode)
         CSR_RUN: begin
            if (sleep_instr) begin
               next_s.status[`CSR_ST_TOUT] = 1'b1;
               next_s.status[`CSR_ST_PDOWN] = 1'b0;
               next_s.mode = idle_select ? CSR_IDLE : CSR_SLEEP;
            end
         end
         CSR_SLEEP, CSR_IDLE: begin
            if (s.wake) begin
               next_s.mode = CSR_RUN;
            end
         end
         default: next_s.mode = CSR_RUN;
      endcase
      if (watchdog_clear_instr) begin
         next_s.status[`CSR_ST_TOUT] = 1'b1;
         next_s.status[`CSR_ST_PDOWN] = 1'b1;
      end
      // wdt restart: timeout 0, power-down kept (0 after a sleep, 1 after a watchdog clear or power-up)
      if (watchdog_timeout) begin
         next_s.status[`CSR_ST_TOUT] = 1'b0;
         next_s.pc = `CSR_RST_PC;
         next_s.sp = '0;
         next_s.mode = CSR_RUN;
      end
      // registered so the low-power flag leaves straight from a flop
      next_s.asleep = (next_s.mode != CSR_RUN);
   end

   // ************************************
   // registers
   // ************************************
   always_ff @(posedge clk_sys) begin
      if (reset_any) begin
         s.rtc <= `CSR_RST_BYTE;
         s.pc <= `CSR_RST_PC;
         // power-up pair is 1/1; a pin reset from sleep keeps power-down low
         if (rst) begin
            s.status <= `CSR_RST_STATUS;
         end else begin
            s.status <= {3'b000, 1'b1, s.status[`CSR_ST_PDOWN], 3'b000};
         end
         s.ram_sel <= `CSR_RST_BYTE;
         s.port5 <= `CSR_RST_BYTE;
         s.port6 <= `CSR_RST_BYTE;
         s.sp <= '0;
         // histories take the pins, so a pin held high is no false edge after reset
         s.rtc_q <= rtc_pin;
         s.irq_a_q <= ext_irq_a_pin;
         s.irq_b_q <= ext_irq_b_pin;
         s.irq_a <= 1'b0;
         s.irq_b <= 1'b0;
         s.pins_q <= pins_now;
         s.wake <= 1'b0;
         s.rdata <= `CSR_RST_BYTE;
         s.iaddr <= `CSR_RST_BYTE;
         s.iwr <= 1'b0;
         s.ird <= 1'b0;
         s.iwdata <= `CSR_RST_BYTE;
         s.asleep <= 1'b0;
         s.mode <= CSR_RUN;
      end else begin
         s <= next_s;
      end
   end

   // stack storage has no reset; entries are written before use
   always_ff @(posedge clk_sys) begin
      if (!reset_any && call_instr && !jump_instr) begin
         stack[s.sp] <= s.pc + 13'h0001;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign indirect_addr = s.iaddr;
   assign indirect_wr = s.iwr;
   assign indirect_rd = s.ird;
   assign indirect_wdata = s.iwdata;
   assign reg_rdata = s.rdata;
   assign pc = s.pc;
   assign control_page_select = s.port5[`CSR_P5_CPAGE];
   assign data_ram_msb = s.port5[`CSR_P5_RAMMSB];
   assign bank_sel = s.ram_sel[7:6];
   assign port5_data = s.port5[7:4];
   assign port6_data = s.port6;
   assign ext_irq_a = s.irq_a;
   assign ext_irq_b = s.irq_b;
   assign wake = s.wake;
   assign sleeping = s.asleep;

   // ************************************
   // checks
   // ************************************
   a_jump_page: assert property (@(posedge clk_sys) disable iff (reset_any)
      jump_instr |=> pc[12:10] == $past(s.status[7:5]) && pc[9:0] == $past(branch_target))
      else $error("jump did not load page and target");
   a_move_keeps_hi: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_PCL && !pc_add && !jump_instr && !call_instr
       && !return_instr && !watchdog_timeout) |=> pc[12:8] == $past(pc[12:8])
       && pc[7:0] == $past(reg_wdata))
      else $error("move to pc wrong");
   a_call_return: assert property (@(posedge clk_sys) disable iff (reset_any)
      (call_instr && !jump_instr && !watchdog_timeout) ##1 (return_instr && !jump_instr
       && !call_instr && !watchdog_timeout) |=> pc == $past(pc, 2) + 13'h0001)
      else $error("return did not restore pc");
   a_sleep_flags: assert property (@(posedge clk_sys) disable iff (reset_any)
      (sleep_instr && !sleeping && !watchdog_clear_instr && !watchdog_timeout)
      |=> s.status[4:3] == 2'b10 && sleeping)
      else $error("sleep flags wrong");
   a_wdt_clear: assert property (@(posedge clk_sys) disable iff (reset_any)
      (watchdog_clear_instr && !watchdog_timeout) |=> s.status[4:3] == 2'b11)
      else $error("watchdog clear flags wrong");
   a_wdt_timeout: assert property (@(posedge clk_sys) disable iff (reset_any)
      watchdog_timeout |=> !s.status[4] && s.status[3] == $past(s.status[3]))
      else $error("watchdog timeout flags wrong");
   a_port5_rsvd: assert property (@(posedge clk_sys) disable iff (reset_any)
      reg_rd && reg_addr == `CSR_ADDR_PORT5 |=> reg_rdata[3:2] == 2'b00)
      else $error("port5 reserved bits not zero");
   a_rtc_tick: assert property (@(posedge clk_sys) disable iff (reset_any)
      (!rtc_from_pin && !(reg_wr && reg_addr == `CSR_ADDR_RTC)) |=> s.rtc == $past(s.rtc) + 8'h01)
      else $error("counter did not tick");
   a_irq_b_fall: assert property (@(posedge clk_sys) disable iff (reset_any)
      ($fell(ext_irq_b_pin)) |=> ext_irq_b)
      else $error("falling edge on irq b missed");
   a_call_load: assert property (@(posedge clk_sys) disable iff (reset_any)
      (call_instr && !jump_instr && !watchdog_timeout)
      |=> pc == {$past(s.status[7:5]), $past(branch_target)})
      else $error("call did not load page and target");
   a_add_keeps_hi: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_PCL && pc_add && !jump_instr && !call_instr
       && !return_instr && !watchdog_timeout) |=> pc[12:8] == $past(pc[12:8])
       && pc[7:0] == $past(pc[7:0]) + $past(reg_wdata))
      else $error("add to pc wrong");
   a_flags_update: assert property (@(posedge clk_sys) disable iff (reset_any)
      flags_we |=> s.status[2:0] == $past({zero_in, nibble_carry_in, carry_in}))
      else $error("alu flags not stored");
   a_status_guard: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_STATUS && !sleep_instr && !watchdog_clear_instr
       && !watchdog_timeout) |=> s.status[4:3] == $past(s.status[4:3])
       && s.status[7:5] == $past(reg_wdata[7:5]))
      else $error("status write wrong");
   a_indirect_wr: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_INDIRECT)
      |=> indirect_wr && indirect_wdata == $past(reg_wdata))
      else $error("indirect write not passed on");
   a_bank_sel: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_RAMSEL) |=> bank_sel == $past(reg_wdata[7:6]))
      else $error("bank select not written");
   a_port5_fields: assert property (@(posedge clk_sys) disable iff (reset_any)
      (reg_wr && reg_addr == `CSR_ADDR_PORT5) |=> port5_data == $past(reg_wdata[7:4])
       && control_page_select == $past(reg_wdata[0]) && data_ram_msb == $past(reg_wdata[1]))
      else $error("port5 fields not written");
   a_irq_a_edge: assert property (@(posedge clk_sys) disable iff (reset_any)
      ((ext_irq_a_rising && $rose(ext_irq_a_pin))
       || (!ext_irq_a_rising && $fell(ext_irq_a_pin))) |=> ext_irq_a)
      else $error("selected edge on irq a missed");
   a_irq_b_quiet: assert property (@(posedge clk_sys) disable iff (reset_any)
      $rose(ext_irq_b_pin) |=> !ext_irq_b)
      else $error("rising edge on irq b flagged");
   a_wake_exit: assert property (@(posedge clk_sys) disable iff (reset_any)
      (wake && sleeping) |=> !sleeping)
      else $error("wake did not leave low power");
   a_wake_only_asleep: assert property (@(posedge clk_sys) disable iff (reset_any)
      wake |-> $past(sleeping))
      else $error("wake raised while running");
endmodule : csr_core

//--- verification/test_csr_core.sv
// self-checking bench for the cpu special register core
`timescale 1ns/10ps
`include "csr_params.svh"
module test_csr_core
   import csr_pkg::*;
;
   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic clk_sys, rst, reset_n_pin, reg_wr, reg_rd;
   logic [5:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, indirect_addr, indirect_wdata, indirect_rdata, va, vb;
   logic indirect_wr, indirect_rd, carry_in, nibble_carry_in, zero_in, idle_select;
   // control pulses: jump call return step add flags sleep wdclear wdtimeout
   logic [8:0] ctl;
   logic [9:0] branch_target;
   logic [12:0] pc;
   logic rtc_pin, rtc_from_pin, infrared_output_pin, ext_irq_a_pin, ext_irq_b_pin;
   logic ext_irq_a_rising, control_page_select, data_ram_msb, ext_irq_a, ext_irq_b;
   logic [7:0] port6_pins, port6_gpio, port8_pins, port8_gpio, port6_data;
   logic [1:0] bank_sel;
   logic [3:0] port5_data;
   logic wake, sleeping;
   logic [2:0] irq_stim [6] = '{3'h6, 3'h7, 3'h4, 3'h0, 3'h2, 3'h0};
   logic [7:0] irq_exp [6] = '{8'h10, 8'h10, 8'h11, 8'h11, 8'h11, 8'h21};
   int n_errors = 0;
   int total_checks = 0;
   int n_ia = 0;
   int n_ib = 0;
   int n_wk = 0;
   int n_iwr = 0;
   int n_ird = 0;
   localparam logic [8:0] JMP_P = 9'h100, CAL_P = 9'h080, RET_P = 9'h040, STP_P = 9'h020;
   localparam logic [8:0] ADD_P = 9'h010, FLG_P = 9'h008, SLP_P = 9'h004, WCL_P = 9'h002;
   localparam logic [8:0] WTO_P = 9'h001;

   csr_core #(.STACK_DEPTH(8)) DUT (.clk_sys, .rst, .reset_n_pin, .reg_wr, .reg_rd,
      .reg_addr, .reg_wdata, .reg_rdata, .indirect_addr, .indirect_wr, .indirect_rd,
      .indirect_wdata, .indirect_rdata, .jump_instr(ctl[8]), .call_instr(ctl[7]),
      .return_instr(ctl[6]), .pc_step(ctl[5]), .pc_add(ctl[4]), .branch_target, .pc,
      .flags_we(ctl[3]), .carry_in, .nibble_carry_in, .zero_in, .sleep_instr(ctl[2]),
      .idle_select, .watchdog_clear_instr(ctl[1]), .watchdog_timeout(ctl[0]), .rtc_pin,
      .rtc_from_pin, .infrared_output_pin, .port6_pins, .port6_gpio, .port8_pins,
      .port8_gpio, .ext_irq_a_pin, .ext_irq_b_pin, .ext_irq_a_rising, .control_page_select,
      .data_ram_msb, .bank_sel, .port5_data, .port6_data, .ext_irq_a, .ext_irq_b, .wake,
      .sleeping);

   // ****************************************
   // clock, pulse counters, tasks
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // one-cycle outputs are counted so no wait has to hunt for them
   always @(posedge clk_sys) begin
      n_ia += (ext_irq_a === 1'b1);
      n_ib += (ext_irq_b === 1'b1);
      n_wk += (wake === 1'b1);
      n_iwr += (indirect_wr === 1'b1);
      n_ird += (indirect_rd === 1'b1);
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task wr(input logic [5:0] a, input logic [7:0] d, input logic [8:0] m = 9'h000);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      ctl <= m;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      ctl <= 9'h000;
      #1;
   endtask : wr
   task rd(input logic [5:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task pulse(input logic [8:0] m);
      @(posedge clk_sys);
      ctl <= m;
      @(posedge clk_sys);
      ctl <= 9'h000;
      #1;
   endtask : pulse

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      {rst, reset_n_pin, reg_wr, reg_rd, ctl} = {1'b1, 1'b1, 11'h000};
      {reg_addr, reg_wdata, indirect_rdata, branch_target} = 32'h0;
      {carry_in, nibble_carry_in, zero_in, idle_select, rtc_pin, rtc_from_pin} = 6'h00;
      {infrared_output_pin, ext_irq_a_pin, ext_irq_b_pin, ext_irq_a_rising} = 4'h1;
      {port6_pins, port8_pins, port6_gpio, port8_gpio} = 32'h0000_0180;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`CSR_ADDR_STATUS, va);
      check(va, 8'h18);
      check(pc, 13'h0000);
      for (int i = 4; i < 8; i++) begin
         rd(i[5:0], va);
         check(va, 8'h00);
      end
      wr(`CSR_ADDR_RAMSEL, 8'hC5);
      // the indirect address copy trails the register by a cycle
      tick(1);
      check({bank_sel, indirect_addr}, 10'h3C5);
      wr(`CSR_ADDR_INDIRECT, 8'h5A);
      tick(2);
      check({n_iwr[7:0], indirect_wdata}, 16'h015A);
      @(posedge clk_sys) indirect_rdata <= 8'h3C;
      rd(`CSR_ADDR_INDIRECT, va);
      tick(1);
      check({n_ird[7:0], va}, 16'h013C);
      wr(`CSR_ADDR_PORT5, 8'hFF);
      rd(`CSR_ADDR_PORT5, va);
      check({va, control_page_select, data_ram_msb, port5_data}, 14'h3CFF);
      wr(`CSR_ADDR_PORT5, 8'hA2);
      rd(`CSR_ADDR_PORT5, va);
      check({va, control_page_select, data_ram_msb, port5_data}, 14'h289A);
      wr(`CSR_ADDR_PORT6, 8'hA5);
      rd(`CSR_ADDR_PORT6, va);
      check({va, port6_data}, 16'hA5A5);
      wr(6'h07, 8'hFF);
      rd(6'h07, va);
      check(va, 8'h00);
      // counter: reads two cycles apart see two ticks, pin mode sees only edges
      rd(`CSR_ADDR_RTC, va);
      rd(`CSR_ADDR_RTC, vb);
      check(8'(vb - va), 8'h02);
      @(posedge clk_sys) rtc_from_pin <= 1'b1;
      wr(`CSR_ADDR_RTC, 8'h40);
      rd(`CSR_ADDR_RTC, va);
      check(va, 8'h40);
      repeat (3) begin
         @(posedge clk_sys) rtc_pin <= 1'b1;
         tick(2);
         @(posedge clk_sys) rtc_pin <= 1'b0;
         tick(2);
      end
      rd(`CSR_ADDR_RTC, vb);
      check(vb, 8'h43);
      // status: bits 3 and 4 refuse writes, flags land in bits 0 to 2
      wr(`CSR_ADDR_STATUS, 8'hA7);
      rd(`CSR_ADDR_STATUS, va);
      check(va, 8'hBF);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys) {zero_in, nibble_carry_in, carry_in} <= i ? 3'h4 : 3'h1;
         pulse(FLG_P);
         rd(`CSR_ADDR_STATUS, va);
         check(va, i ? 8'hBC : 8'hB9);
      end
      // program flow under page 5
      @(posedge clk_sys) branch_target <= 10'h2AB;
      pulse(JMP_P);
      check(pc, 13'h16AB);
      @(posedge clk_sys) branch_target <= 10'h155;
      pulse(CAL_P);
      check(pc, 13'h1555);
      pulse(RET_P);
      check(pc, 13'h16AC);
      // back-to-back call and return land on the address just pushed
      @(posedge clk_sys) ctl <= CAL_P;
      @(posedge clk_sys) ctl <= RET_P;
      @(posedge clk_sys) ctl <= 9'h000;
      #1;
      check(pc, 13'h16AD);
      wr(`CSR_ADDR_PCL, 8'h12);
      check(pc, 13'h1612);
      pulse(STP_P);
      wr(`CSR_ADDR_PCL, 8'hF0, ADD_P);
      check(pc, 13'h1603);
      // wake sources: a disabled port bit must stay quiet
      pulse(SLP_P);
      rd(`CSR_ADDR_STATUS, va);
      check({va & 8'h18, 7'h00, sleeping}, 16'h1001);
      @(posedge clk_sys) port6_pins <= 8'h02;
      tick(4);
      check(n_wk, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         // the last two rounds sleep in idle mode, which the same pins must leave
         @(posedge clk_sys) idle_select <= i[1];
         if (i > 0)
            pulse(SLP_P);
         tick(2);
         @(posedge clk_sys);
         case (i)
            0: port6_pins <= 8'h03;
            1: infrared_output_pin <= 1'b1;
            2: port8_pins <= 8'h80;
            default: rtc_pin <= 1'b1;
         endcase
         tick(4);
         check({n_wk[7:0], 7'h00, sleeping}, {i[7:0] + 8'h01, 8'h00});
      end
      // restart events and the timeout/power-down pair
      pulse(WCL_P);
      rd(`CSR_ADDR_STATUS, va);
      check(va & 8'h18, 8'h18);
      pulse(SLP_P);
      pulse(WTO_P);
      check(pc, 13'h0000);
      rd(`CSR_ADDR_STATUS, va);
      check(va & 8'h18, 8'h00);
      pulse(WCL_P);
      pulse(WTO_P);
      rd(`CSR_ADDR_STATUS, va);
      check(va & 8'h18, 8'h08);
      pulse(SLP_P);
      @(posedge clk_sys) reset_n_pin <= 1'b0;
      tick(2);
      @(posedge clk_sys) reset_n_pin <= 1'b1;
      rd(`CSR_ADDR_STATUS, va);
      check({va & 8'h18, 3'h0, pc}, 24'h100000);
      // interrupt edges: a follows its select, b only falls
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys) {ext_irq_a_rising, ext_irq_a_pin, ext_irq_b_pin} <= irq_stim[i];
         tick(4);
         check({n_ia[3:0], n_ib[3:0]}, irq_exp[i]);
      end
      close_out();
   end
   // hang guard, far beyond the sequence length
   initial begin
      #2000000;
      n_errors++;
      close_out();
   end
endmodule : test_csr_core
